// ---- hw/dram_row_refresh_and_repair.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "dram_rr_params.svh"
module dram_row_refresh_and_repair #(
  parameter int unsigned TMRD_CYC = `NS_TO_CYC(`TMRD_NS), // mode register delay
  parameter int unsigned TRP_CYC = `NS_TO_CYC(`TRP_NS), // precharge period
  parameter int unsigned TPGM_CYC = `MS_TO_CYC(`TPGM_MS) // fuse programming time
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // decoded command from the controller
  input wire logic i_cmd_valid,
  input wire dram_rr_pkg::cmd_e i_cmd,
  input wire dram_rr_pkg::bank_t i_cmd_bank,
  input wire dram_rr_pkg::row_t i_cmd_row,
  input wire logic [5:0] i_mr_addr,
  input wire logic [7:0] i_mr_wdata,
  // mode register read
  input wire logic i_mrr_valid,
  output logic o_mrr_valid,
  output logic [7:0] o_mrr_data,
  // targeted refresh status and restore requests
  output logic o_trr_active,
  output logic o_refresh_count_hold,
  output logic o_victim_restore,
  output dram_rr_pkg::bank_t o_victim_bank,
  output dram_rr_pkg::row_t o_victim_row,
  // row repair
  output logic o_ppr_active,
  output logic o_fuse_program,
  output dram_rr_pkg::bank_t o_fuse_bank,
  output dram_rr_pkg::row_t o_fuse_row
);
  localparam int unsigned EXIT_CYC = TRP_CYC + TMRD_CYC; // self-clear delay

  // refuse settings the timer cannot hold
  if (TPGM_CYC >= (1 << `TIMER_W) || EXIT_CYC < 1 || TPGM_CYC < 1) begin : g_bad
    $error("timing parameter out of range");
  end

  // all state of the block
  typedef struct packed {
    dram_rr_pkg::state_e st; // main state
    logic [7:0] ctrl; // row refresh control register
    logic [7:0] rep_en; // repair enable register
    logic [7:0] rep_stat; // repair status, one bit per bank
    logic [`TIMER_W-1:0] timer; // shared delay counter
    dram_rr_pkg::bank_t fbank; // bank being repaired
    dram_rr_pkg::row_t frow; // row being repaired
    logic mrr_v; // read answer strobe
    logic [7:0] mrr_d; // read answer data
  } top_s;
  top_s q, d;

  trr_link_if lnk();

  trr_tracker u_tracker (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .lnk(lnk)
  );

  // feed the tracker
  assign lnk.en = q.ctrl[`TRR_EN_BIT];
  assign lnk.bank = q.ctrl[`TRR_BANK_HI:`TRR_BANK_LO];
  assign lnk.cmd_valid = i_cmd_valid;
  assign lnk.cmd = i_cmd;
  assign lnk.cmd_bank = i_cmd_bank;
  assign lnk.cmd_row = i_cmd_row;

  logic wr_ctrl; // write to the row refresh control register
  logic wr_rep; // write to the repair enable register
  assign wr_ctrl = i_cmd_valid && i_cmd == dram_rr_pkg::CMD_MRW &&
                   i_mr_addr == `ROW_REFRESH_CTRL_ADDR;
  assign wr_rep = i_cmd_valid && i_cmd == dram_rr_pkg::CMD_MRW &&
                  i_mr_addr == `REPAIR_ENABLE_ADDR;

  // next-state logic
  always_comb begin
    d = q;
    d.mrr_v = 1'b0;
    // register writes
    if (wr_ctrl) begin
      if (i_mr_wdata[`TRR_EN_BIT]) begin
        d.ctrl = i_mr_wdata;
      end else begin
        // exit or abort: bank bits are don't care, keep ours
        d.ctrl[`TRR_EN_BIT] = 1'b0;
        d.ctrl[`TRR_BANK_LO-1:0] = i_mr_wdata[`TRR_BANK_LO-1:0];
      end
    end
    if (wr_rep) begin
      d.rep_en = i_mr_wdata;
    end
    // sequencing
    case (q.st)
      dram_rr_pkg::ST_IDLE: begin
        if (d.ctrl[`TRR_EN_BIT]) begin
          d.st = dram_rr_pkg::ST_TRR;
        end else if (d.rep_en[`PPR_EN_BIT]) begin
          d.st = dram_rr_pkg::ST_PPR_ARMED;
        end
      end
      dram_rr_pkg::ST_TRR: begin
        if (!d.ctrl[`TRR_EN_BIT]) begin
          d.st = dram_rr_pkg::ST_IDLE; // interrupted or exited early
        end else if (lnk.third_pre) begin
          d.st = dram_rr_pkg::ST_TRR_EXIT;
          d.timer = `TIMER_W'(EXIT_CYC - 1);
        end
      end
      dram_rr_pkg::ST_TRR_EXIT: begin
        if (!d.ctrl[`TRR_EN_BIT]) begin
          d.st = dram_rr_pkg::ST_IDLE; // software exit
        end else if (q.timer == '0) begin
          d.ctrl[`TRR_EN_BIT] = 1'b0;
          d.st = dram_rr_pkg::ST_IDLE;
        end else begin
          d.timer = q.timer - `TIMER_W'(1);
        end
      end
      dram_rr_pkg::ST_PPR_ARMED: begin
        if (!d.rep_en[`PPR_EN_BIT]) begin
          d.st = dram_rr_pkg::ST_IDLE;
        end else if (i_cmd_valid && i_cmd == dram_rr_pkg::CMD_ACT) begin
          // failing row address arrives with the activate
          d.st = dram_rr_pkg::ST_PPR_PROG;
          d.fbank = i_cmd_bank;
          d.frow = i_cmd_row;
          d.timer = `TIMER_W'(TPGM_CYC - 1);
        end
      end
      dram_rr_pkg::ST_PPR_PROG: begin
        if (q.timer != '0) begin
          d.timer = q.timer - `TIMER_W'(1);
        end
        if (i_cmd_valid && (i_cmd == dram_rr_pkg::CMD_PRE ||
                            i_cmd == dram_rr_pkg::CMD_PRE_ALL)) begin
          // a full programming interval burns one spare row per bank
          if (q.timer == '0) begin
            d.rep_stat[q.fbank] = 1'b1;
          end
          d.st = dram_rr_pkg::ST_PPR_ARMED;
        end
      end
      default: begin
        d.st = dram_rr_pkg::ST_IDLE;
      end
    endcase
    // mode register read
    if (i_mrr_valid) begin
      d.mrr_v = 1'b1;
      case (i_mr_addr)
        `ROW_REFRESH_CTRL_ADDR: d.mrr_d = q.ctrl;
        `REPAIR_STATUS_ADDR: d.mrr_d = q.rep_stat;
        `REPAIR_ENABLE_ADDR: d.mrr_d = q.rep_en;
        default: d.mrr_d = 8'h00;
      endcase
    end
  end

  // state register
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      q.st <= dram_rr_pkg::ST_IDLE;
      q.ctrl <= `MR_RESET;
      q.rep_en <= `MR_RESET;
      q.rep_stat <= `MR_RESET;
      q.timer <= '0;
      q.fbank <= '0;
      q.frow <= '0;
      q.mrr_v <= 1'b0;
      q.mrr_d <= 8'h00;
    end else begin
      q <= d;
    end
  end

  // outputs
  assign o_mrr_valid = q.mrr_v;
  assign o_mrr_data = q.mrr_d;
  assign o_trr_active = q.ctrl[`TRR_EN_BIT];
  assign o_refresh_count_hold = q.ctrl[`TRR_EN_BIT];
  assign o_victim_restore = lnk.restore;
  assign o_victim_bank = q.ctrl[`TRR_BANK_HI:`TRR_BANK_LO];
  assign o_victim_row = lnk.restore_row;
  assign o_ppr_active = q.rep_en[`PPR_EN_BIT];
  assign o_fuse_program = (q.st == dram_rr_pkg::ST_PPR_PROG);
  assign o_fuse_bank = q.fbank;
  assign o_fuse_row = q.frow;
endmodule : dram_row_refresh_and_repair
`default_nettype wire

// ---- hw/dram_rr_params.svh ----
// How it works
// - bit 7 set enables, clear disables refresh
// - bits 6..4 pick the target bank
// - enable self-clears after third precharge plus delay
// - exit write ignores the bank field
// - three activates, three precharges; all-bank counts
// - enable holds counter; target activates restore victims
// - 8-bit repair status, one row per bank
`ifndef DRAM_RR_PARAMS_SVH
`define DRAM_RR_PARAMS_SVH
// mode register addresses
`define ROW_REFRESH_CTRL_ADDR 6'h18
`define REPAIR_STATUS_ADDR 6'h19
`define REPAIR_ENABLE_ADDR 6'h04
// field positions
`define TRR_EN_BIT 7
`define TRR_BANK_HI 6
`define TRR_BANK_LO 4
`define PPR_EN_BIT 4
// reset values
`define MR_RESET 8'h00
`define CNT_RESET 2'h0
// sequence length in precharges and activates
`define TRR_STEPS 2'h3
// timing figures
`define CLK_MHZ 250
`define TMRD_NS 14
`define TRP_NS 18
`define TPGM_MS 1000
`define NS_TO_CYC(ns) ((((ns) * `CLK_MHZ) + 999) / 1000)
`define MS_TO_CYC(ms) ((ms) * `CLK_MHZ * 1000)
`define TIMER_W 28
`endif

// ---- hw/dram_rr_pkg.sv ----
package dram_rr_pkg;
  // decoded command from the command/address decoder
  typedef enum logic [2:0] {
    CMD_NONE = 3'h0,
    CMD_ACT = 3'h1,
    CMD_PRE = 3'h2,
    CMD_PRE_ALL = 3'h3,
    CMD_MRW = 3'h4,
    CMD_REF = 3'h5,
    CMD_SRE = 3'h6,
    CMD_OTHER = 3'h7
  } cmd_e;
  // main state, gray on every step except ST_TRR_EXIT to ST_IDLE
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_TRR = 3'b001,
    ST_TRR_EXIT = 3'b011,
    ST_PPR_ARMED = 3'b010,
    ST_PPR_PROG = 3'b110
  } state_e;
  typedef logic [16:0] row_t;
  typedef logic [2:0] bank_t;
endpackage : dram_rr_pkg

// ---- hw/trr_link_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface trr_link_if;
  logic en; // mode enabled
  dram_rr_pkg::bank_t bank; // target bank
  logic cmd_valid; // command strobe
  dram_rr_pkg::cmd_e cmd; // decoded command
  dram_rr_pkg::bank_t cmd_bank; // command bank
  dram_rr_pkg::row_t cmd_row; // command row
  logic third_pre; // pulse: third target precharge seen
  logic restore; // pulse: victim restore request
  dram_rr_pkg::row_t restore_row; // aggressor row
  logic [1:0] pre_cnt; // precharges seen
  modport main (output en, bank, cmd_valid, cmd, cmd_bank, cmd_row,
                input third_pre, restore, restore_row, pre_cnt);
  modport tracker (input en, bank, cmd_valid, cmd, cmd_bank, cmd_row,
                   output third_pre, restore, restore_row, pre_cnt);
endinterface : trr_link_if
`default_nettype wire

// ---- hw/trr_tracker.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "dram_rr_params.svh"
module trr_tracker (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // link to the main block
  trr_link_if.tracker lnk
);
  // all tracker state
  typedef struct packed {
    logic [1:0] act_cnt; // target activates seen
    logic [1:0] pre_cnt; // target precharges seen
    logic third_pre; // completion pulse
    logic restore; // restore pulse
    dram_rr_pkg::row_t row; // last aggressor row
  } trk_s;
  trk_s q, d;
  logic hit; // command addresses the target bank
  // next-state logic: counts the aggressor sequence
  always_comb begin
    d = q;
    d.third_pre = 1'b0;
    d.restore = 1'b0;
    hit = lnk.cmd_valid && (lnk.cmd_bank == lnk.bank);
    if (!lnk.en) begin
      // counts drop whenever the mode is off
      d.act_cnt = `CNT_RESET;
      d.pre_cnt = `CNT_RESET;
    end else begin
      if (hit && lnk.cmd == dram_rr_pkg::CMD_ACT && q.act_cnt != `TRR_STEPS) begin
        // aggressor activate: restore neighbours, step the activate count
        d.act_cnt = q.act_cnt + 2'h1;
        d.restore = 1'b1;
        d.row = lnk.cmd_row;
      end
      if (((hit && lnk.cmd == dram_rr_pkg::CMD_PRE) ||
           (lnk.cmd_valid && lnk.cmd == dram_rr_pkg::CMD_PRE_ALL)) &&
          q.pre_cnt != `TRR_STEPS) begin
        // precharge-all also closes the target bank
        d.pre_cnt = q.pre_cnt + 2'h1;
        d.third_pre = (q.pre_cnt == (`TRR_STEPS - 2'h1));
      end
    end
  end
  // state register
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
  // outputs straight from flops
  assign lnk.third_pre = q.third_pre;
  assign lnk.restore = q.restore;
  assign lnk.restore_row = q.row;
  assign lnk.pre_cnt = q.pre_cnt;
endmodule : trr_tracker
`default_nettype wire

// ---- testbench/lpddr_ctrl_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module lpddr_ctrl_model (
  // requests from the bench
  input wire logic i_clk, i_rstn, i_req, i_rd, i_busy,
  input wire dram_rr_pkg::cmd_e i_kind,
  input wire dram_rr_pkg::bank_t i_bank,
  input wire dram_rr_pkg::row_t i_row,
  input wire logic [5:0] i_addr,
  input wire logic [7:0] i_data,
  // command lines to the device
  output var logic o_cmd_valid, o_mrr_valid,
  output var dram_rr_pkg::cmd_e o_cmd,
  output var dram_rr_pkg::bank_t o_cmd_bank,
  output var dram_rr_pkg::row_t o_cmd_row,
  output var logic [5:0] o_mr_addr,
  output var logic [7:0] o_mr_wdata
);
  // one command per strobe; idle lines toggle so stale values never pass as valid
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_cmd_valid <= 1'b0;
      o_mrr_valid <= 1'b0;
      o_cmd <= dram_rr_pkg::CMD_NONE;
      {o_cmd_bank, o_cmd_row, o_mr_addr, o_mr_wdata} <= '0;
    end else begin
      // refresh and self refresh withheld while a maintenance mode runs
      o_cmd_valid <= i_req && !(i_busy && i_kind inside {dram_rr_pkg::CMD_REF,
        dram_rr_pkg::CMD_SRE});
      o_mrr_valid <= i_rd;
      o_cmd <= i_kind;
      if (i_req || i_rd) begin
        {o_cmd_bank, o_cmd_row, o_mr_addr, o_mr_wdata} <= {i_bank, i_row, i_addr, i_data};
      end else begin
        {o_cmd_bank, o_cmd_row, o_mr_addr, o_mr_wdata} <=
          ~{o_cmd_bank, o_cmd_row, o_mr_addr, o_mr_wdata};
      end
    end
  end
endmodule : lpddr_ctrl_model
`default_nettype wire

// ---- testbench/rr_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module rr_props #(
  parameter int unsigned TMRD_CYC = 4,
  parameter int unsigned TRP_CYC = 5,
  parameter int unsigned TPGM_CYC = 20
) (
  // inputs of the block, plus its bank, row and read data outputs
  input wire logic i_clk, i_rstn, i_cmd_valid, i_mrr_valid,
  input wire dram_rr_pkg::cmd_e i_cmd,
  input wire dram_rr_pkg::bank_t i_cmd_bank, o_victim_bank, o_fuse_bank,
  input wire dram_rr_pkg::row_t i_cmd_row, o_victim_row, o_fuse_row,
  input wire logic [5:0] i_mr_addr,
  input wire logic [7:0] i_mr_wdata, o_mrr_data,
  // outputs of the block
  input wire logic o_mrr_valid, o_trr_active, o_refresh_count_hold, o_victim_restore,
  input wire logic o_ppr_active, o_fuse_program
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  // entry write to the control register from idle
  sequence s_trr_on;
    i_cmd_valid && i_cmd == dram_rr_pkg::CMD_MRW && i_mr_addr == 6'h18 && i_mr_wdata[7]
      && !o_trr_active && !o_ppr_active;
  endsequence
  // write that clears the enable bit
  sequence s_trr_off;
    i_cmd_valid && i_cmd == dram_rr_pkg::CMD_MRW && i_mr_addr == 6'h18 && !i_mr_wdata[7];
  endsequence
  a_mrr_answer: assert property (i_mrr_valid |=> o_mrr_valid)
    else $error("read not answered");
  a_mrr_single: assert property (!i_mrr_valid |=> !o_mrr_valid)
    else $error("spurious read answer");
  a_mrr_unmapped: assert property (i_mrr_valid && !(i_mr_addr inside {6'h18, 6'h19, 6'h04})
    |=> o_mrr_data == 8'h00) else $error("unmapped read not zero");
  a_trr_enter: assert property (s_trr_on |=> o_trr_active)
    else $error("mode not entered");
  a_trr_exit: assert property (s_trr_off |=> !o_trr_active)
    else $error("mode not left");
  a_hold_level: assert property (o_refresh_count_hold == o_trr_active)
    else $error("counter hold differs from mode");
  a_restore_cause: assert property (o_victim_restore |-> $past(i_cmd_valid) && $past(o_trr_active)
    && $past(i_cmd) == dram_rr_pkg::CMD_ACT && o_victim_row == $past(i_cmd_row))
    else $error("restore without activate");
  a_ppr_enter: assert property (i_cmd_valid && i_cmd == dram_rr_pkg::CMD_MRW
    && i_mr_addr == 6'h04 && i_mr_wdata[4] && !o_trr_active |=> o_ppr_active)
    else $error("repair not enabled");
  a_fuse_start: assert property (o_ppr_active && !o_fuse_program && i_cmd_valid
    && i_cmd == dram_rr_pkg::CMD_ACT |=> o_fuse_program && o_fuse_row == $past(i_cmd_row))
    else $error("programming not started");
  a_fuse_guard: assert property ($rose(o_fuse_program) |-> o_ppr_active)
    else $error("programming outside repair");
endmodule : rr_props
bind dram_row_refresh_and_repair rr_props #(.TMRD_CYC(TMRD_CYC), .TRP_CYC(TRP_CYC),
  .TPGM_CYC(TPGM_CYC)) rr_props_i (.i_clk, .i_rstn, .i_cmd_valid, .i_mrr_valid, .i_cmd,
  .i_cmd_bank, .o_victim_bank, .o_fuse_bank, .i_cmd_row, .o_victim_row, .o_fuse_row,
  .i_mr_addr, .i_mr_wdata, .o_mrr_data, .o_mrr_valid, .o_trr_active, .o_refresh_count_hold,
  .o_victim_restore, .o_ppr_active, .o_fuse_program);
`default_nettype wire

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic i_clk, i_rstn, i_cmd_valid, i_mrr_valid, o_mrr_valid, o_trr_active;
  logic o_refresh_count_hold, o_victim_restore, o_ppr_active, o_fuse_program, req, rd;
  dram_rr_pkg::cmd_e i_cmd, kind;
  dram_rr_pkg::bank_t i_cmd_bank, o_victim_bank, o_fuse_bank, bnk, bb, b0;
  dram_rr_pkg::row_t i_cmd_row, o_victim_row, o_fuse_row, row;
  logic [5:0] i_mr_addr, adr;
  logic [7:0] i_mr_wdata, o_mrr_data, dat;
  logic [31:0] seed;
  int fails, n_tests, cyc;
  dram_row_refresh_and_repair #(.TMRD_CYC(2), .TRP_CYC(3), .TPGM_CYC(20))
    dram_row_refresh_and_repair_i (.i_clk, .i_rstn, .i_cmd_valid, .i_cmd, .i_cmd_bank,
    .i_cmd_row, .i_mr_addr, .i_mr_wdata, .i_mrr_valid, .o_mrr_valid, .o_mrr_data,
    .o_trr_active, .o_refresh_count_hold, .o_victim_restore, .o_victim_bank, .o_victim_row,
    .o_ppr_active, .o_fuse_program, .o_fuse_bank, .o_fuse_row);
  lpddr_ctrl_model lpddr_ctrl_model_i (.i_clk, .i_rstn, .i_req(req), .i_rd(rd),
    .i_busy(o_trr_active | o_fuse_program), .i_kind(kind), .i_bank(bnk), .i_row(row),
    .i_addr(adr), .i_data(dat), .o_cmd_valid(i_cmd_valid), .o_mrr_valid(i_mrr_valid),
    .o_cmd(i_cmd), .o_cmd_bank(i_cmd_bank), .o_cmd_row(i_cmd_row), .o_mr_addr(i_mr_addr),
    .o_mr_wdata(i_mr_wdata));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : final_report
  // one request through the controller model; returns just after the taking edge
  task automatic op(input logic rq, rdq, input dram_rr_pkg::cmd_e kk, input
    dram_rr_pkg::bank_t b, input dram_rr_pkg::row_t r, input logic [5:0] a, input logic [7:0] d);
    @(posedge i_clk);
    {req, rd, kind, bnk, row, adr, dat} <= {rq, rdq, kk, b, r, a, d};
    @(posedge i_clk);
    {req, rd} <= 2'h0;
    @(posedge i_clk);
    #1;
  endtask : op
  task automatic mrw(input logic [5:0] a, input logic [7:0] d);
    op(1'b1, 1'b0, dram_rr_pkg::CMD_MRW, 3'h0, 17'h0_0000, a, d);
  endtask : mrw
  task automatic cmd(input dram_rr_pkg::cmd_e k, input dram_rr_pkg::bank_t b);
    seed = xs(seed);
    op(1'b1, 1'b0, k, b, seed[16:0], 6'h00, 8'h00);
  endtask : cmd
  task automatic rdr(input logic [5:0] a, input logic [7:0] e);
    op(1'b0, 1'b1, dram_rr_pkg::CMD_NONE, 3'h0, 17'h0_0000, a, 8'h00);
    chk(o_mrr_valid, 1);
    chk(o_mrr_data, e);
  endtask : rdr
  // full refresh sequence on bank b, second precharge given as all-bank
  task automatic trr_run(input dram_rr_pkg::bank_t b);
    mrw(6'h18, {1'b1, b, 4'h0});
    chk(o_trr_active, 1);
    cmd(dram_rr_pkg::CMD_REF, b);
    for (int i = 0; i < 3; i++) begin
      // only the target bank sees traffic; one aggressor row per victim
      cmd(dram_rr_pkg::CMD_ACT, b);
      chk({o_victim_restore, o_victim_bank, o_victim_row}, {1'b1, b, row});
      cmd(i == 1 ? dram_rr_pkg::CMD_PRE_ALL : dram_rr_pkg::CMD_PRE, b);
      chk(o_refresh_count_hold, 1);
    end
    repeat (4) @(posedge i_clk);
    #1 chk(o_trr_active, 1);
    repeat (4) @(posedge i_clk);
    #1 chk(o_trr_active, 0);
  endtask : trr_run
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  // cut a hang short
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      final_report();
    end
  end
  initial begin
    {i_rstn, req, rd, bnk, row, adr, dat} = '0;
    kind = dram_rr_pkg::CMD_NONE;
    seed = 32'h0000_d748;
    repeat (6) @(posedge i_clk);
    i_rstn <= 1'b1;
    rdr(6'h18, 8'h00);
    rdr(6'h04, 8'h00);
    rdr(6'h05, 8'h00);
    for (int i = 0; i < 8; i++) trr_run(3'(i));
    // interrupted sequence, cleared and rerun
    seed = xs(seed);
    bb = seed[2:0];
    mrw(6'h18, {1'b1, bb, 4'h0});
    cmd(dram_rr_pkg::CMD_ACT, bb);
    cmd(dram_rr_pkg::CMD_PRE, bb);
    mrw(6'h18, 8'h00);
    chk(o_trr_active, 0);
    repeat (3) cmd(dram_rr_pkg::CMD_PRE, bb);
    trr_run(bb);
    mrw(6'h18, 8'h70);
    chk(o_trr_active, 0);
    // repair: first attempt cut short, second programmed
    b0 = 3'(xs(seed) >> 7);
    for (int j = 0; j < 2; j++) begin
      bb = b0 + 3'(j);
      mrw(6'h04, 8'h10);
      chk(o_ppr_active, 1);
      cmd(dram_rr_pkg::CMD_ACT, bb);
      chk({o_fuse_program, o_fuse_bank, o_fuse_row}, {1'b1, bb, row});
      if (j == 1) repeat (22) @(posedge i_clk);
      cmd(dram_rr_pkg::CMD_PRE, bb);
      mrw(6'h04, 8'h00);
      chk(o_ppr_active, 0);
    end
    rdr(6'h19, 8'h01 << (b0 + 3'h1));
    final_report();
  end
endmodule : tb_top
`default_nettype wire
